// ---- inc/idc_pkg.sv ----
// constants, encodings and types for the instruction decode and timing block
package idc_pkg;

  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PTR_W = 16;

  // file address field spans the whole bank window
  localparam logic [6:0] FILE_ADDR_MIN = 7'h00;
  localparam logic [6:0] FILE_ADDR_MAX = 7'h7f;
  // indirect-access ports sit at the bottom of every bank
  localparam logic [6:0] IND_PORT0 = 7'h00;
  localparam logic [6:0] IND_PORT1 = 7'h01;

  // oscillator clocks per instruction cycle
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] CYC_ONE = 2'h1;

  // field positions inside the 14-bit word
  localparam int TOP_HI = 13;
  localparam int TOP_LO = 12;
  localparam int OP_HI = 11;
  localparam int OP_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int BIT_HI = 9;
  localparam int BIT_LO = 7;
  localparam int PTRN_BIT = 2;
  localparam int PTR_MSB = 15;

  // top two bits of the word
  localparam logic [1:0] TOP_BYTE = 2'h0;
  localparam logic [1:0] TOP_BIT = 2'h1;
  localparam logic [1:0] TOP_FLOW = 2'h2;
  localparam logic [1:0] TOP_LIT = 2'h3;

  // fixed whole-word control operations
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_INTERRUPT_RETURN = 14'h0009;
  localparam logic [13:0] OP_INVOKE_BY_ACCUM = 14'h000a;
  localparam logic [13:0] OP_REL_JUMP_BY_ACCUM = 14'h000b;
  // bits 13..3 of the indirect move group
  localparam logic [10:0] OP_IND_LOAD = 11'h002;
  localparam logic [10:0] OP_IND_STORE = 11'h003;

  // byte operations, bits 11..8 under top 00
  localparam logic [3:0] BOP_STORE_ACC = 4'h0;
  localparam logic [3:0] BOP_CLEAR = 4'h1;
  localparam logic [3:0] BOP_SUB = 4'h2;
  localparam logic [3:0] BOP_DEC = 4'h3;
  localparam logic [3:0] BOP_IOR = 4'h4;
  localparam logic [3:0] BOP_AND = 4'h5;
  localparam logic [3:0] BOP_XOR = 4'h6;
  localparam logic [3:0] BOP_ADD = 4'h7;
  localparam logic [3:0] BOP_MOVE = 4'h8;
  localparam logic [3:0] BOP_COMP = 4'h9;
  localparam logic [3:0] BOP_INC = 4'ha;
  localparam logic [3:0] BOP_DEC_SKIP = 4'hb;
  localparam logic [3:0] BOP_ROT_RIGHT = 4'hc;
  localparam logic [3:0] BOP_ROT_LEFT = 4'hd;
  localparam logic [3:0] BOP_SWAP = 4'he;
  localparam logic [3:0] BOP_INC_SKIP = 4'hf;
  // byte operations under top 11
  localparam logic [3:0] XOP_SHL = 4'h5;
  localparam logic [3:0] XOP_SHR = 4'h6;
  localparam logic [3:0] XOP_ASHR = 4'h7;
  localparam logic [3:0] XOP_SUB_BORROW = 4'hb;
  localparam logic [3:0] XOP_ADD_CARRY = 4'hd;
  // literal and control operations under top 11
  localparam logic [3:0] LOP_MOVE = 4'h0;
  localparam logic [3:0] LOP_REL_JUMP0 = 4'h2;
  localparam logic [3:0] LOP_REL_JUMP1 = 4'h3;
  localparam logic [3:0] LOP_RETURN_LIT = 4'h4;
  localparam logic [3:0] LOP_IOR = 4'h8;
  localparam logic [3:0] LOP_AND = 4'h9;
  localparam logic [3:0] LOP_XOR = 4'ha;
  localparam logic [3:0] LOP_SUB = 4'hc;
  localparam logic [3:0] LOP_ADD = 4'he;
  // bit operations, bits 11..10 under top 01
  localparam logic [1:0] BIT_CLEAR = 2'h0;
  localparam logic [1:0] BIT_SET = 2'h1;
  localparam logic [1:0] BIT_SKIP_CLEAR = 2'h2;
  localparam logic [1:0] BIT_SKIP_SET = 2'h3;

  // pointer update modes
  localparam logic [1:0] MM_PRE_INC = 2'h0;
  localparam logic [1:0] MM_PRE_DEC = 2'h1;
  localparam logic [1:0] MM_POST_INC = 2'h2;
  localparam logic [1:0] MM_POST_DEC = 2'h3;

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } idc_phase_type;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_EXTRA = 3'b010,
    ST_NOP = 3'b100
  } idc_state_type;

  typedef enum logic [1:0] {
    CL_BYTE = 2'h0,
    CL_BIT = 2'h1,
    CL_LIT = 2'h2
  } idc_class_type;

endpackage : idc_pkg

// ---- hdl/idc_phase_gen.sv ----
// four-phase sequencer splitting each instruction cycle into oscillator clocks
`timescale 1ns/1ps
`default_nettype none
module idc_phase_gen
  import idc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  output var idc_phase_type phase
);

  idc_phase_type next_phase;

  always_comb begin
    unique case (phase)
      PH_Q1: next_phase = PH_Q2;
      PH_Q2: next_phase = PH_Q3;
      PH_Q3: next_phase = PH_Q4;
      PH_Q4: next_phase = PH_Q1;
      default: next_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase <= PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

endmodule : idc_phase_gen
`default_nettype wire

// ---- hdl/idc_core.sv ----
// instruction decode, cycle timing and read-modify-write sequencing
// Notes on behaviour
// - every instruction is one 14-bit word with opcode and all operands.
// - each opcode falls in exactly one class: byte, bit, literal/control.
// - an instruction takes one cycle unless an exception below applies.
// - both subroutine calls take two cycles.
// - return, return with literal and interrupt return take two cycles.
// - jumps, and skips or counted skips that skip, take two cycles.
// - indirect reference with pointer in program memory adds one cycle.
// - one instruction cycle is four oscillator clocks.
// - file operands are read, modified and stored; read even if write-only.
// - destination bit 0 sends result to accumulator, 1 to file register.
// - file address field selects 0x00 to 0x7f in the current bank.
// - bit field selects one bit of the addressed 8-bit register.
// - don't-care bits of a word never change execution.
// - pointer number field picks pointer and indirect port pair 0 or 1.
// - two-bit mode picks pre/post increment/decrement of the pointer.
// - program counter change or true test costs two cycles, second a nop.
// - indirect port access adds a cycle when the pointer msb is set.
// - word 0x000b is the relative jump by accumulator, two cycles.
// - word 0x000a is the subroutine invoke by accumulator, two cycles.
`timescale 1ns/1ps
`default_nettype none
module idc_core
  import idc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WORD_W-1:0] insn_word,
  input wire logic [PTR_W-1:0] ptr0,
  input wire logic [PTR_W-1:0] ptr1,
  input wire logic [DATA_W-1:0] rf_rdata,
  output logic insn_take,
  output logic rf_rd,
  output logic rf_wr,
  output logic [FADDR_W-1:0] rf_addr,
  output logic [DATA_W-1:0] rf_wdata,
  output logic [DATA_W-1:0] accum,
  output logic carry,
  output logic [1:0] insn_class,
  output logic [2:0] bit_pos,
  output logic dest_file,
  output logic ptr_step,
  output logic ptr_num,
  output logic [1:0] ptr_mode,
  output logic program_counter_load,
  output logic call_push,
  output logic return_pop,
  output logic insn_done,
  output logic [1:0] insn_cycles
);

  idc_phase_type phase;
  idc_state_type state;
  idc_state_type next_state;
  logic [WORD_W-1:0] ir;
  logic [DATA_W-1:0] opnd;
  logic nop_after;
  logic [1:0] cyc;

  idc_phase_gen u_phase (
    .clk(clk),
    .resetn(resetn),
    .phase(phase)
  );

  // byte ALU: {carry valid, carry, result}
  function automatic logic [9:0] byte_alu(input logic [3:0] op,
      input logic ext, input logic [7:0] f, input logic [7:0] w,
      input logic c);
    logic [8:0] s;
    s = 9'h000;
    byte_alu = {2'b00, f};
    if (ext) begin
      case (op)
        XOP_SHL: byte_alu = {1'b1, f[7], f[6:0], 1'b0};
        XOP_SHR: byte_alu = {1'b1, f[0], 1'b0, f[7:1]};
        XOP_ASHR: byte_alu = {1'b1, f[0], f[7], f[7:1]};
        XOP_SUB_BORROW: begin
          s = {1'b0, f} + {1'b0, ~w} + {8'h00, c};
          byte_alu = {1'b1, s};
        end
        XOP_ADD_CARRY: begin
          s = {1'b0, f} + {1'b0, w} + {8'h00, c};
          byte_alu = {1'b1, s};
        end
        default: byte_alu = {2'b00, f};
      endcase
    end else begin
      unique case (op)
        BOP_STORE_ACC: byte_alu = {2'b00, w};
        BOP_CLEAR: byte_alu = 10'h000;
        BOP_SUB: begin
          s = {1'b0, f} + {1'b0, ~w} + 9'h001;
          byte_alu = {1'b1, s};
        end
        BOP_DEC, BOP_DEC_SKIP: byte_alu = {2'b00, f - 8'h01};
        BOP_IOR: byte_alu = {2'b00, f | w};
        BOP_AND: byte_alu = {2'b00, f & w};
        BOP_XOR: byte_alu = {2'b00, f ^ w};
        BOP_ADD: begin
          s = {1'b0, f} + {1'b0, w};
          byte_alu = {1'b1, s};
        end
        BOP_MOVE: byte_alu = {2'b00, f};
        BOP_COMP: byte_alu = {2'b00, ~f};
        BOP_INC, BOP_INC_SKIP: byte_alu = {2'b00, f + 8'h01};
        BOP_ROT_RIGHT: byte_alu = {1'b1, f[0], c, f[7:1]};
        BOP_ROT_LEFT: byte_alu = {1'b1, f[7], f[6:0], c};
        BOP_SWAP: byte_alu = {2'b00, f[3:0], f[7:4]};
      endcase
    end
  endfunction : byte_alu

  // literal ALU: {accumulator write, carry valid, carry, result}
  function automatic logic [10:0] lit_alu(input logic [3:0] op,
      input logic [7:0] k, input logic [7:0] w);
    logic [8:0] s;
    s = 9'h000;
    case (op)
      LOP_MOVE, LOP_RETURN_LIT: lit_alu = {3'b100, k};
      LOP_IOR: lit_alu = {3'b100, k | w};
      LOP_AND: lit_alu = {3'b100, k & w};
      LOP_XOR: lit_alu = {3'b100, k ^ w};
      LOP_SUB: begin
        s = {1'b0, k} + {1'b0, ~w} + 9'h001;
        lit_alu = {2'b11, s};
      end
      LOP_ADD: begin
        s = {1'b0, k} + {1'b0, w};
        lit_alu = {2'b11, s};
      end
      // bank/page selects and indexed moves live outside this block
      default: lit_alu = {3'b000, w};
    endcase
  endfunction : lit_alu

  // decode of the held word
  wire [1:0] top = ir[TOP_HI:TOP_LO];
  wire [3:0] op = ir[OP_HI:OP_LO];
  wire ctrl_low = (top == TOP_BYTE) && (ir[OP_HI:DEST_BIT] == 5'h00);
  wire ext_byte = (top == TOP_LIT) && ((op == XOP_SHL) || (op == XOP_SHR) ||
      (op == XOP_ASHR) || (op == XOP_SUB_BORROW) || (op == XOP_ADD_CARRY));
  wire is_byte = ((top == TOP_BYTE) && !ctrl_low) || ext_byte;
  wire is_bit = (top == TOP_BIT);
  wire [1:0] cls = is_byte ? CL_BYTE : (is_bit ? CL_BIT : CL_LIT);
  wire is_ind_load = (ir[TOP_HI:3] == OP_IND_LOAD);
  wire is_ind_store = (ir[TOP_HI:3] == OP_IND_STORE);
  wire is_ind_move = is_ind_load || is_ind_store;
  wire file_op = is_byte || is_bit;
  // the clear-accumulator form names no file: its low bits must stay inert
  wire clr_acc = is_byte && !ext_byte && (op == BOP_CLEAR) &&
      !ir[DEST_BIT];
  wire file_ref = file_op && !clr_acc;
  wire ptr_sel = ir[PTRN_BIT];
  wire [6:0] faddr = is_ind_move ? {6'h00, ptr_sel} : ir[6:0];
  wire ind_ref = (file_ref || is_ind_move) && (faddr <= IND_PORT1);
  wire [15:0] ind_ptr = faddr[0] ? ptr1 : ptr0;
  wire need_extra = ind_ref && ind_ptr[PTR_MSB];
  wire d_bit = ir[DEST_BIT];
  wire [2:0] bsel = ir[BIT_HI:BIT_LO];
  wire [1:0] bit_op = ir[OP_HI:10];

  // flow control; whole-word compares keep the don't-care bits of the
  // clear-accumulator form out of it, since it sits in the byte class
  wire is_call = (top == TOP_FLOW) && !ir[OP_HI];
  wire is_abs_jump = (top == TOP_FLOW) && ir[OP_HI];
  wire is_call_acc = (ir == OP_INVOKE_BY_ACCUM);
  wire is_rel_acc = (ir == OP_REL_JUMP_BY_ACCUM);
  wire is_rel = (top == TOP_LIT) &&
      ((op == LOP_REL_JUMP0) || (op == LOP_REL_JUMP1));
  wire is_ret = (ir == OP_RETURN);
  wire is_iret = (ir == OP_INTERRUPT_RETURN);
  wire is_ret_lit = (top == TOP_LIT) && (op == LOP_RETURN_LIT);
  wire any_call = is_call || is_call_acc;
  wire any_ret = is_ret || is_iret || is_ret_lit;
  wire flow = any_call || any_ret || is_abs_jump || is_rel || is_rel_acc;

  // execution results
  wire [9:0] bres = byte_alu(op, ext_byte, opnd, accum, carry);
  wire [10:0] lres = lit_alu(op, ir[7:0], accum);
  wire [7:0] bmask = 8'h01 << bsel;
  wire bit_val = |(opnd & bmask);
  wire [7:0] bit_res = (bit_op == BIT_SET) ? (opnd | bmask) :
      (opnd & ~bmask);
  wire counted_skip = is_byte && !ext_byte &&
      ((op == BOP_DEC_SKIP) || (op == BOP_INC_SKIP)) && (bres[7:0] == 8'h00);
  wire bit_skip = is_bit &&
      (((bit_op == BIT_SKIP_CLEAR) && !bit_val) ||
       ((bit_op == BIT_SKIP_SET) && bit_val));
  wire taken = flow || counted_skip || bit_skip;
  // byte ops store per the destination bit; bit set/clear always store
  wire wr_file = (is_byte && d_bit) ||
      (is_bit && !bit_op[1]) || is_ind_store;
  wire wr_acc_byte = is_byte && !d_bit;
  wire [7:0] file_res = is_bit ? bit_res :
      (is_ind_store ? accum : bres[7:0]);

  wire at_q1 = (phase == PH_Q1);
  wire at_q2 = (phase == PH_Q2);
  wire at_q3 = (phase == PH_Q3);
  wire at_q4 = (phase == PH_Q4);
  wire run = (state == ST_RUN);

  always_comb begin
    unique case (state)
      ST_RUN: begin
        if (need_extra) begin
          next_state = ST_EXTRA;
        end else if (taken) begin
          next_state = ST_NOP;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_EXTRA: next_state = nop_after ? ST_NOP : ST_RUN;
      ST_NOP: next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  wire last_cycle = at_q4 && (next_state == ST_RUN);

  // sequencing state and the held word
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_RUN;
      ir <= 14'h0000;
      opnd <= 8'h00;
      nop_after <= 1'b0;
      cyc <= CYC_ONE;
    end else begin
      if (at_q1 && run) begin
        ir <= insn_word;
      end
      if (at_q3 && run) begin
        opnd <= rf_rdata;
      end
      if (at_q4) begin
        state <= next_state;
        if (run) begin
          nop_after <= taken;
        end
        cyc <= (next_state == ST_RUN) ? CYC_ONE : cyc + 2'h1;
      end
    end
  end

  // fetch hand-shake and file register strobes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      insn_take <= 1'b1;
      rf_rd <= 1'b0;
      rf_wr <= 1'b0;
      rf_addr <= FILE_ADDR_MIN;
      rf_wdata <= 8'h00;
    end else begin
      insn_take <= at_q4 && (next_state == ST_RUN);
      // read every file operand, also for store-only operations
      // indirect stores read too, so every write follows its read
      rf_rd <= at_q2 && run && (file_ref || is_ind_move);
      rf_wr <= at_q4 && run && wr_file;
      if (at_q2 && run) begin
        rf_addr <= faddr;
      end
      if (at_q4 && run) begin
        rf_wdata <= file_res;
      end
    end
  end

  // accumulator and carry
  always_ff @(posedge clk) begin
    if (!resetn) begin
      accum <= 8'h00;
      carry <= 1'b0;
    end else if (at_q4 && run) begin
      if (wr_acc_byte) begin
        accum <= bres[7:0];
      end else if (is_ind_load) begin
        accum <= opnd;
      end else if (!file_op && lres[10]) begin
        accum <= lres[7:0];
      end
      if (is_byte && bres[9]) begin
        carry <= bres[8];
      end else if (!file_op && lres[9]) begin
        carry <= lres[8];
      end
    end
  end

  // decoded fields, flow pulses and completion report
  always_ff @(posedge clk) begin
    if (!resetn) begin
      insn_class <= CL_BYTE;
      bit_pos <= 3'h0;
      dest_file <= 1'b1;
      ptr_step <= 1'b0;
      ptr_num <= 1'b0;
      ptr_mode <= MM_PRE_INC;
      program_counter_load <= 1'b0;
      call_push <= 1'b0;
      return_pop <= 1'b0;
      insn_done <= 1'b0;
      insn_cycles <= CYC_ONE;
    end else begin
      if (at_q2 && run) begin
        insn_class <= cls;
        bit_pos <= bsel;
        dest_file <= is_byte ? d_bit : 1'b1;
        ptr_num <= ptr_sel;
        ptr_mode <= ir[1:0];
      end
      ptr_step <= at_q4 && run && is_ind_move;
      program_counter_load <= at_q4 && run && flow;
      call_push <= at_q4 && run && any_call;
      return_pop <= at_q4 && run && any_ret;
      insn_done <= last_cycle;
      if (last_cycle) begin
        insn_cycles <= cyc;
      end
    end
  end

endmodule : idc_core
`default_nettype wire

// ---- dv/idc_core_props.sv ----
// port-level assertions for the decode and cycle-timing core
`timescale 1ns/1ps
`default_nettype none
module idc_core_props
  import idc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic insn_take,
  input wire logic rf_rd,
  input wire logic rf_wr,
  input wire logic [FADDR_W-1:0] rf_addr,
  input wire logic [1:0] insn_class,
  input wire logic dest_file,
  input wire logic program_counter_load,
  input wire logic call_push,
  input wire logic return_pop,
  input wire logic insn_done,
  input wire logic [1:0] insn_cycles
);
  logic [3:0] gap;
  // clocks since the last fetch; three cycles of four clocks at the most
  always_ff @(posedge clk) begin
    if (!resetn) gap <= 4'h0;
    else if (insn_take) gap <= 4'h1;
    else gap <= gap + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_quiet3;
    !insn_take [*3];
  endsequence
  sequence s_addr_held;
    $stable(rf_addr) [*3];
  endsequence
  a_take_spacing: assert property (insn_take |=> s_quiet3)
    else $error("fetch inside one instruction cycle");
  a_cycle_count: assert property (insn_done |-> gap == {insn_cycles, 2'h0})
    else $error("instruction length disagrees with cycles used");
  a_read_slot: assert property (rf_rd |-> $past(insn_take, 2))
    else $error("file read outside the third clock");
  a_write_after_read: assert property (rf_wr |-> $past(rf_rd, 2))
    else $error("file write without the read before it");
  a_done_fetch: assert property (insn_done |-> insn_take)
    else $error("completion without the next fetch");
  a_flow_load: assert property (call_push || return_pop |-> program_counter_load)
    else $error("call or return without counter load");
  a_addr_held: assert property (rf_rd |=> s_addr_held)
    else $error("file address moved during the operation");
  a_write_dest: assert property (rf_wr |-> dest_file)
    else $error("file written with accumulator destination");
  a_class_legal: assert property (insn_class != 2'h3)
    else $error("unknown instruction class");
endmodule : idc_core_props
bind idc_core idc_core_props idc_core_props_inst (.clk, .resetn, .insn_take,
  .rf_rd, .rf_wr, .rf_addr, .insn_class, .dest_file, .program_counter_load,
  .call_push, .return_pop, .insn_done, .insn_cycles);
`default_nettype wire

// ---- dv/idc_prog_mem.sv ----
// program memory model handing instruction words to the core
`timescale 1ns/1ps
`default_nettype none
module idc_prog_mem
  import idc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic insn_take,
  input wire logic pm_wr,
  input wire logic [3:0] pm_addr,
  input wire logic [WORD_W-1:0] pm_data,
  output logic [WORD_W-1:0] insn_word
);
  // blank slots hold zero words, don't-care bits emitted as zero
  logic [WORD_W-1:0] mem [16] = '{default: 14'h0000};
  logic [3:0] pc = 4'h0;
  // no branch targets are followed: the fetch address only steps
  always @(posedge clk) begin
    if (pm_wr) mem[pm_addr] <= pm_data;
    if (!resetn) pc <= 4'h0;
    else if (insn_take) pc <= pc + 4'h1;
  end
  assign insn_word = mem[pc];
endmodule : idc_prog_mem
`default_nettype wire

// ---- dv/idc_core_tb.sv ----
// self-checking bench for the decode and cycle-timing core
`timescale 1ns/1ps
`default_nettype none
module idc_core_tb;
  import idc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [PTR_W-1:0] ptr0 = 16'h0000;
  logic [PTR_W-1:0] ptr1 = 16'h0000;
  logic [DATA_W-1:0] rf_rdata = 8'h00;
  logic pm_wr = 1'b0;
  logic [3:0] pm_addr = 4'h0;
  logic [WORD_W-1:0] pm_data = 14'h0000;
  logic [WORD_W-1:0] insn_word;
  logic insn_take, rf_rd, rf_wr, dest_file, ptr_step, ptr_num, carry;
  logic program_counter_load, call_push, return_pop, insn_done;
  logic [FADDR_W-1:0] rf_addr;
  logic [DATA_W-1:0] rf_wdata, accum;
  logic [2:0] bit_pos;
  logic [1:0] insn_class, ptr_mode, insn_cycles;
  int miscompares = 0;
  int num_checks = 0;
  localparam logic [7:0] ACC0 = 8'h3c;
  always #12.5 clk = ~clk;
  idc_prog_mem idc_prog_mem_inst (.clk, .resetn, .insn_take, .pm_wr,
    .pm_addr, .pm_data, .insn_word);
  idc_core idc_core_inst (.clk, .resetn, .insn_word, .ptr0, .ptr1, .rf_rdata,
    .insn_take, .rf_rd, .rf_wr, .rf_addr, .rf_wdata, .accum, .carry,
    .insn_class, .bit_pos, .dest_file, .ptr_step, .ptr_num, .ptr_mode,
    .program_counter_load, .call_push, .return_pop, .insn_done, .insn_cycles);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic tick();
    @(posedge clk);
    #2;
  endtask : tick
  // preload the accumulator, run one word, return its length and strobes
  task automatic exec(input logic [13:0] w, input logic [7:0] rd,
      input logic [15:0] p0, input logic [15:0] p1, output int n,
      output logic [5:0] s);
    n = 0;
    s = 6'h00;
    resetn = 1'b0;
    pm_wr = 1'b1;
    pm_addr = 4'h0;
    pm_data = {TOP_LIT, LOP_MOVE, ACC0};
    tick();
    pm_addr = 4'h1;
    pm_data = w;
    rf_rdata = rd;
    ptr0 = p0;
    ptr1 = p1;
    tick();
    pm_wr = 1'b0;
    resetn = 1'b1;
    for (int k = 0; k < 8 && insn_done !== 1'b1; k++) tick();
    do begin
      tick();
      n++;
      s |= {rf_rd, rf_wr, program_counter_load, call_push, return_pop,
        ptr_step};
    end while (insn_done !== 1'b1 && n < 16);
  endtask : exec
  task automatic t_byte();
    int n;
    logic [5:0] s;
    exec({TOP_BYTE, BOP_ADD, 1'b1, 7'h25}, 8'h11, 16'h0, 16'h0, n, s);
    check(16'(n), 16'h4);
    check(s, 6'h30);
    check({rf_addr, rf_wdata}, {7'h25, 8'h4d});
    check(insn_class, CL_BYTE);
    exec({TOP_BYTE, BOP_ADD, 1'b0, 7'h7f}, 8'h11, 16'h0, 16'h0, n, s);
    check({s, accum, rf_addr, dest_file}, {6'h20, 8'h4d, 7'h7f, 1'b0});
    exec({TOP_LIT, XOP_ADD_CARRY, 1'b0, 7'h7f}, 8'hd0, 16'h0, 16'h0, n, s);
    check({s, insn_class, accum, carry}, {6'h20, CL_BYTE, 8'h0c, 1'b1});
    exec({TOP_BYTE, BOP_CLEAR, 1'b1, 7'h40}, 8'h99, 16'h0, 16'h0, n, s);
    check({s, rf_wdata}, {6'h30, 8'h00});
  endtask : t_byte
  task automatic t_bits();
    int n;
    logic [5:0] s;
    exec({TOP_BIT, BIT_SET, 3'h5, 7'h7f}, 8'h01, 16'h0, 16'h0, n, s);
    check({insn_class, bit_pos, rf_wdata}, {CL_BIT, 3'h5, 8'h21});
    exec({TOP_BIT, BIT_CLEAR, 3'h0, 7'h33}, 8'hff, 16'h0, 16'h0, n, s);
    check({s, rf_wdata}, {6'h30, 8'hfe});
  endtask : t_bits
  task automatic t_skip();
    int n;
    logic [5:0] s;
    logic [13:0] w [4] = '{{TOP_BIT, BIT_SKIP_SET, 3'h3, 7'h20},
      {TOP_BIT, BIT_SKIP_CLEAR, 3'h3, 7'h20},
      {TOP_BYTE, BOP_DEC_SKIP, 1'b1, 7'h20},
      {TOP_BYTE, BOP_INC_SKIP, 1'b1, 7'h20}};
    logic [7:0] y [4] = '{8'h08, 8'hf7, 8'h01, 8'hff};
    logic [7:0] z [4] = '{8'hf7, 8'h08, 8'h02, 8'hfe};
    for (int i = 0; i < 4; i++) begin
      exec(w[i], y[i], 16'h0, 16'h0, n, s);
      check(16'(n), 16'h8);
      exec(w[i], z[i], 16'h0, 16'h0, n, s);
      check(16'(n), 16'h4);
    end
  endtask : t_skip
  task automatic t_flow();
    int n;
    logic [5:0] s;
    logic [13:0] w [8] = '{{2'h2, 1'b0, 11'h123}, {2'h2, 1'b1, 11'h045},
      {TOP_LIT, 3'h1, 9'h1ff}, OP_INVOKE_BY_ACCUM, OP_REL_JUMP_BY_ACCUM,
      OP_RETURN, OP_INTERRUPT_RETURN, {TOP_LIT, LOP_RETURN_LIT, 8'h5a}};
    logic [1:0] e [8] = '{2'h2, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1, 2'h1, 2'h1};
    for (int i = 0; i < 8; i++) begin
      exec(w[i], 8'h00, 16'h0, 16'h0, n, s);
      check(16'(n), 16'h8);
      check(s[3:1], {1'b1, e[i]});
      check(insn_class, CL_LIT);
    end
    check(accum, 8'h5a);
  endtask : t_flow
  task automatic t_ind();
    int n;
    logic [5:0] s;
    exec({TOP_BYTE, BOP_ADD, 1'b1, IND_PORT0}, 8'h01, 16'h8000, 16'h0, n, s);
    check(16'(n), 16'h8);
    exec({TOP_BYTE, BOP_ADD, 1'b1, IND_PORT0}, 8'h01, 16'h7fff, 16'h8000, n, s);
    check(16'(n), 16'h4);
    exec({TOP_BYTE, BOP_ADD, 1'b1, IND_PORT1}, 8'h01, 16'h7fff, 16'h8000, n, s);
    check(16'(n), 16'h8);
    exec({TOP_BYTE, BOP_DEC_SKIP, 1'b1, IND_PORT0}, 8'h01, 16'h8000, 16'h0, n, s);
    check({16'(n), insn_cycles}, {16'hc, 2'h3});
    for (int i = 0; i < 8; i++) begin
      exec({OP_IND_LOAD, 3'(i)}, 8'h00, 16'h0, 16'h0, n, s);
      check({s[0], ptr_num, ptr_mode}, {1'b1, 3'(i)});
      check(16'(n), 16'h4);
    end
    exec({OP_IND_STORE, 3'h4}, 8'h00, 16'h0, 16'hffff, n, s);
    check(16'(n), 16'h8);
  endtask : t_ind
  task automatic t_dontcare();
    int n;
    logic [5:0] s;
    for (int i = 0; i < 4; i += 3) begin
      exec(14'h0100 | 14'(i), 8'h77, 16'h8000, 16'h8000, n, s);
      check({16'(n), s, accum}, {16'h4, 6'h00, 8'h00});
    end
  endtask : t_dontcare
  initial begin
    repeat (10) @(posedge clk);
    #2;
    t_byte();
    t_bits();
    t_skip();
    t_flow();
    t_ind();
    t_dontcare();
    stop_test();
  end
  // the run needs some 11 us; a hang is cut off well past that
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule : idc_core_tb
`default_nettype wire
